// *** mcm_cfg.svh ***
`ifndef MCM_CFG_SVH
`define MCM_CFG_SVH

// Clock and serial timing
`define MCM_CLK_PS        25000
`define MCM_BIT_NS        32000
`define MCM_BIT_CYC       ((`MCM_BIT_NS * 1000) / `MCM_CLK_PS)

// Synchronised pin vector layout
`define MCM_NPIN          11
`define MCM_PIN_RX        0
`define MCM_PIN_OMNI      1
`define MCM_PIN_CODE3     2
`define MCM_PIN_CODE2     3
`define MCM_PIN_CODE1     4
`define MCM_PIN_CODE0     5
`define MCM_PIN_MUTE_EN   6
`define MCM_PIN_FBOARD    7
`define MCM_PIN_PLUG      8
`define MCM_PIN_MAIN      9
`define MCM_PIN_SUB       10

// Register word offsets (byte address = 4 * index)
`define MCM_REG_CTRL      2'h0
`define MCM_REG_STATUS    2'h1
`define MCM_REG_PRESET    2'h2

// Control register fields and reset value
`define MCM_CTRL_CHAN_LSB 0
`define MCM_CTRL_BYP_BIT  2
`define MCM_CTRL_RESET    3'h0

// Message decoding
`define MCM_PRESET_RESET  8'h01
`define MCM_CC_VOLUME     7'h07
`define MCM_MUTE_MAX      7'h05
`define MCM_ST_PROG       4'hc
`define MCM_ST_CTRL       4'hb
`define MCM_ST_PRESS      4'hd
`define MCM_ST_SYSTEM     8'hf0
`define MCM_ST_REALTIME   8'hf8

`endif

// *** mcm_midi_ctrl.sv ***
// Functional notes
// - Program changes accepted only on switch-selected channel, one of sixteen, unless omni.
// - Omni switch OFF accepts every channel, other channel switches ignored.
// - Switches two to five form channel code, two is MSB; all OFF is channel 1.
// - Mute enable switch gates controller 7 muting; OFF means never muted.
// - Controller 7 value 0 to 5 mutes; larger value restores master volume.
// - Everything on the MIDI input is echoed unchanged on the thru output.
// - Detected footboard on serial port makes the MIDI input ignored.
// - Plug in channel footswitch jack overrides panel channel and bypass selection.
// - Mono contact picks main channel; stereo contact picks sub channel.
// - Main one maps to clean/crunch, main two to lead one/lead two.
// - Preset 1 is active from power-up until a program change arrives.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "mcm_cfg.svh"

module mcm_midi_ctrl
	import mcm_pkg::*;
#(
	parameter int BIT_CYC = `MCM_BIT_CYC
) (
	input  wire logic        mclk,            // 40 MHz clock
	input  wire logic        rst_b,           // Async reset, active low
	input  wire logic        midi_in,         // MIDI input line, idle high
	input  wire logic [6:1]  enc_sw,          // Encoding switches, high is ON
	input  wire logic        footboard_det,   // Footboard seen on serial port
	input  wire logic        fsw_plug,        // Plug present in channel jack
	input  wire logic        fsw_main,        // Mono contact, main channel
	input  wire logic        secondary_channel_select, // Stereo contact
	input  wire logic [1:0]  avs_address,     // Word address
	input  wire logic        avs_read,        // Read request
	input  wire logic        avs_write,       // Write request
	input  wire logic [31:0] avs_writedata,   // Write data
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes
	output logic [31:0]      avs_readdata,    // Read data
	output logic             avs_waitrequest, // Stall
	output logic             midi_thru,       // Echo of MIDI input
	output logic [7:0]       preset,          // Active preset, 1 to 128
	output logic             preset_load,     // Pulse on accepted program change
	output logic             master_mute,     // Master volume muted
	output logic [1:0]       channel,         // 0 clean 1 crunch 2 lead1 3 lead2
	output logic             bypass           // Preamp defeat
);

	mcm_state_t q;
	mcm_state_t d;

	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       omni;
	logic [3:0] code;
	logic       accept;
	logic       prog_hit;
	logic       vol_hit;
	logic [`MCM_NPIN-1:0] pins;

	function automatic logic [31:0] status_word(input mcm_state_t s);
		status_word = {14'h0000, s.f[`MCM_PIN_SUB], s.f[`MCM_PIN_MAIN],
			s.f[`MCM_PIN_PLUG], s.f[`MCM_PIN_FBOARD], s.f[`MCM_PIN_MUTE_EN],
			s.f[`MCM_PIN_OMNI], s.f[`MCM_PIN_CODE3], s.f[`MCM_PIN_CODE2],
			s.f[`MCM_PIN_CODE1], s.f[`MCM_PIN_CODE0], 4'h0,
			s.mute, s.byp, s.chan};
	endfunction

	assign pins = {secondary_channel_select, fsw_main, fsw_plug, footboard_det,
		enc_sw[6], enc_sw[5], enc_sw[4], enc_sw[3], enc_sw[2], enc_sw[1], midi_in};

	mcm_uart_rx #(
		.BIT_CYC (BIT_CYC)
	) u_rx (
		.mclk  (mclk),
		.rst_b (rst_b),
		.rx    (q.f[`MCM_PIN_RX]),
		.data  (rx_byte),
		.valid (rx_valid)
	);

	always_comb begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// A pin change counts once the last two stages agree
		d.f = ((q.s2 ^ q.s3) & q.f) | (~(q.s2 ^ q.s3) & q.s3);
		d.thru = q.f[`MCM_PIN_RX];
		d.prog_stb = 1'b0;

		omni = ~q.f[`MCM_PIN_OMNI];
		code = {q.f[`MCM_PIN_CODE3], q.f[`MCM_PIN_CODE2],
			q.f[`MCM_PIN_CODE1], q.f[`MCM_PIN_CODE0]};
		accept = ~q.f[`MCM_PIN_FBOARD] && (omni || q.run_st[3:0] == code);
		prog_hit = 1'b0;
		vol_hit = 1'b0;

		if (rx_valid) begin
			if (rx_byte[7]) begin
				if (rx_byte >= `MCM_ST_REALTIME) begin
					d.run_st = q.run_st;
				end else if (rx_byte >= `MCM_ST_SYSTEM) begin
					// System data cancels running status
					d.run_st = 8'h00;
					d.have1 = 1'b0;
				end else begin
					d.run_st = rx_byte;
					d.have1 = 1'b0;
				end
			end else if (q.run_st[7]) begin
				case (q.run_st[7:4])
					`MCM_ST_PROG: begin
						if (accept) begin
							prog_hit = 1'b1;
							d.preset = {1'b0, rx_byte[6:0]} + 8'h01;
							d.prog_stb = 1'b1;
						end
					end
					`MCM_ST_PRESS: begin
						d.have1 = 1'b0;
					end
					`MCM_ST_CTRL: begin
						d.have1 = ~q.have1;
						d.d1 = rx_byte;
						if (q.have1 && q.d1[6:0] == `MCM_CC_VOLUME && accept) begin
							vol_hit = 1'b1;
							d.mute = (rx_byte[6:0] <= `MCM_MUTE_MAX);
						end
					end
					default: begin
						// Three-byte messages have their data bytes skipped in pairs
						d.have1 = ~q.have1;
					end
				endcase
			end
		end
		if (!q.f[`MCM_PIN_MUTE_EN]) begin
			d.mute = 1'b0;
		end

		if (q.f[`MCM_PIN_PLUG]) begin
			d.chan = {q.f[`MCM_PIN_MAIN], q.f[`MCM_PIN_SUB]};
			d.byp = 1'b0;
		end else begin
			d.chan = q.ctrl[`MCM_CTRL_CHAN_LSB +: 2];
			d.byp = q.ctrl[`MCM_CTRL_BYP_BIT];
		end

		// One stall cycle, then answer for exactly one cycle
		if (q.wait_r) begin
			if (avs_read || avs_write) begin
				d.wait_r = 1'b0;
				case (avs_address)
					`MCM_REG_CTRL:   d.rdata = {29'h0, q.ctrl};
					`MCM_REG_STATUS: d.rdata = status_word(q);
					`MCM_REG_PRESET: d.rdata = {24'h0, q.preset};
					default:         d.rdata = 32'h0;
				endcase
			end
		end else begin
			d.wait_r = 1'b1;
			if (avs_write && avs_byteenable[0] && avs_address == `MCM_REG_CTRL) begin
				d.ctrl = avs_writedata[2:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{s1: '1, s2: '1, s3: '1, f: {{(`MCM_NPIN-1){1'b0}}, 1'b1},
				thru: 1'b1, run_st: 8'h00, have1: 1'b0, d1: 8'h00,
				preset: `MCM_PRESET_RESET, prog_stb: 1'b0, mute: 1'b0,
				chan: 2'h0, byp: 1'b0, ctrl: `MCM_CTRL_RESET,
				wait_r: 1'b1, rdata: 32'h0};
		end else begin
			q <= d;
		end
	end

	assign avs_readdata    = q.rdata;
	assign avs_waitrequest = q.wait_r;
	assign midi_thru       = q.thru;
	assign preset          = q.preset;
	assign preset_load     = q.prog_stb;
	assign master_mute     = q.mute;
	assign channel         = q.chan;
	assign bypass          = q.byp;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// A pin level is echoed once it has stood still for two samples
	thru_echo_a: assert property ($past(midi_in, 4) == $past(midi_in, 5) &&
		$past(midi_in, 5) == $past(midi_in, 6) |-> midi_thru == $past(midi_in, 5))
		else $error("thru output does not follow the MIDI input");

	prog_load_a: assert property (prog_hit |=>
		preset == {1'b0, $past(rx_byte[6:0])} + 8'h01 && preset_load)
		else $error("accepted program change not loaded");

	load_pulse_a: assert property (preset_load |=> !preset_load)
		else $error("preset load pulse longer than one cycle");

	preset_only_a: assert property (!prog_hit |=> $stable(preset) && !preset_load)
		else $error("preset moved without an accepted program change");

	preset_range_a: assert property (preset != 8'h00)
		else $error("preset number out of range");

	fboard_block_a: assert property (q.f[`MCM_PIN_FBOARD] |=>
		$stable(preset) && !preset_load)
		else $error("program change taken while footboard present");

	fboard_mute_a: assert property (q.f[`MCM_PIN_FBOARD] && q.f[`MCM_PIN_MUTE_EN] |=>
		master_mute == $past(master_mute))
		else $error("mute changed while footboard present");

	chan_filter_a: assert property (rx_valid && !rx_byte[7] &&
		q.run_st[7:4] == `MCM_ST_PROG && q.f[`MCM_PIN_OMNI] && q.run_st[3:0] != code
		|=> $stable(preset))
		else $error("program change taken on a foreign channel");

	omni_take_a: assert property (rx_valid && !rx_byte[7] &&
		q.run_st[7:4] == `MCM_ST_PROG && !q.f[`MCM_PIN_OMNI] && !q.f[`MCM_PIN_FBOARD]
		|=> preset_load)
		else $error("omni mode missed a program change");

	// Realtime bytes may fall between the bytes of any message
	realtime_keep_a: assert property (rx_valid && rx_byte >= `MCM_ST_REALTIME |=>
		q.run_st == $past(q.run_st))
		else $error("realtime byte disturbed running status");

	cc_other_a: assert property (rx_valid && !rx_byte[7] &&
		q.run_st[7:4] == `MCM_ST_CTRL && q.have1 && q.d1[6:0] != `MCM_CC_VOLUME
		&& q.f[`MCM_PIN_MUTE_EN] |=> master_mute == $past(master_mute))
		else $error("controller other than 7 changed the mute");

	mute_hold_a: assert property (!vol_hit && q.f[`MCM_PIN_MUTE_EN] |=>
		master_mute == $past(master_mute))
		else $error("mute changed without a controller 7 value");

	mute_gate_a: assert property (!q.f[`MCM_PIN_MUTE_EN] |=> !master_mute)
		else $error("muted while mute switch off");

	mute_value_a: assert property (vol_hit && q.f[`MCM_PIN_MUTE_EN] |=>
		master_mute == ($past(rx_byte[6:0]) <= `MCM_MUTE_MAX))
		else $error("controller 7 value gives wrong mute");

	fsw_override_a: assert property (q.f[`MCM_PIN_PLUG] |=>
		channel == {$past(q.f[`MCM_PIN_MAIN]), $past(q.f[`MCM_PIN_SUB])} && !bypass)
		else $error("footswitch did not override channel");

	panel_chan_a: assert property (!q.f[`MCM_PIN_PLUG] |=>
		channel == $past(q.ctrl[1:0]) && bypass == $past(q.ctrl[2]))
		else $error("panel channel not followed without footswitch");

	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	wait_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest
		|=> avs_waitrequest)
		else $error("bus answered without a request");

	// A write lands only at the edge where the stall is seen low
	ctrl_write_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address == `MCM_REG_CTRL |=> q.ctrl == $past(avs_writedata[2:0]))
		else $error("control write did not land");

	ro_write_a: assert property (avs_write && avs_address != `MCM_REG_CTRL
		|=> $stable(q.ctrl))
		else $error("write to read-only word changed control");

	prog_seen_c: cover property (preset_load ##[1:1000] preset_load);
	mute_seen_c: cover property ($rose(master_mute) ##[1:1000] $fell(master_mute));
	fsw_seen_c: cover property (q.f[`MCM_PIN_PLUG] ##1 channel == 2'h3 && !bypass);
	wr_seen_c: cover property (avs_write && !avs_waitrequest);
	rd_seen_c: cover property (avs_read && !avs_waitrequest);

endmodule

`default_nettype wire

// *** mcm_midi_src.sv ***
`timescale 1ns/100ps
`default_nettype none

module mcm_midi_src #(
	parameter int BIT_CYC = 16
) (
	input  wire logic mclk, // Clock that paces the bits
	output var logic  tx    // Serial line, idle high
);
	initial tx = 1'b1;

	// Frames are 8N1, LSB first; the line returns to the idle level between bytes
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk);
			tx <= f[i];
			repeat (BIT_CYC - 1) @(posedge mclk);
		end
	endtask
endmodule

`default_nettype wire

// *** mcm_pkg.sv ***
`include "mcm_cfg.svh"

package mcm_pkg;

	typedef enum logic [1:0] {
		MCM_RX_IDLE  = 2'b00,
		MCM_RX_START = 2'b01,
		MCM_RX_DATA  = 2'b10,
		MCM_RX_STOP  = 2'b11
	} mcm_rx_state_t;

	typedef struct packed {
		mcm_rx_state_t st;
		logic [11:0]   cnt;
		logic [2:0]    bit_idx;
		logic [7:0]    shift;
		logic [7:0]    data;
		logic          valid;
	} mcm_rx_t;

	typedef struct packed {
		logic [`MCM_NPIN-1:0] s1;
		logic [`MCM_NPIN-1:0] s2;
		logic [`MCM_NPIN-1:0] s3;
		logic [`MCM_NPIN-1:0] f;
		logic                 thru;
		logic [7:0]           run_st;
		logic                 have1;
		logic [7:0]           d1;
		logic [7:0]           preset;
		logic                 prog_stb;
		logic                 mute;
		logic [1:0]           chan;
		logic                 byp;
		logic [2:0]           ctrl;
		logic                 wait_r;
		logic [31:0]          rdata;
	} mcm_state_t;

endpackage

// *** mcm_uart_rx.sv ***
`timescale 1ns/100ps
`default_nettype none

`include "mcm_cfg.svh"

module mcm_uart_rx
	import mcm_pkg::*;
#(
	parameter int BIT_CYC = `MCM_BIT_CYC
) (
	input  wire logic       mclk,     // System clock
	input  wire logic       rst_b,    // Async reset, active low
	input  wire logic       rx,       // Filtered serial line, idle high
	output logic [7:0]      data,     // Received byte
	output logic            valid     // One-cycle pulse per good byte
);

	localparam logic [11:0] FULL = 12'(BIT_CYC - 1);
	localparam logic [11:0] HALF = 12'(BIT_CYC / 2 - 1);

	mcm_rx_t q;
	mcm_rx_t d;

	always_comb begin
		d = q;
		d.valid = 1'b0;
		case (q.st)
			MCM_RX_IDLE: begin
				d.cnt = HALF;
				if (!rx) begin
					d.st = MCM_RX_START;
				end
			end
			MCM_RX_START: begin
				if (q.cnt != 12'h000) begin
					d.cnt = q.cnt - 12'h001;
				end else if (rx) begin
					// Glitch shorter than half a bit
					d.st = MCM_RX_IDLE;
				end else begin
					d.cnt = FULL;
					d.bit_idx = 3'h0;
					d.st = MCM_RX_DATA;
				end
			end
			MCM_RX_DATA: begin
				if (q.cnt != 12'h000) begin
					d.cnt = q.cnt - 12'h001;
				end else begin
					d.cnt = FULL;
					d.shift = {rx, q.shift[7:1]};
					d.bit_idx = q.bit_idx + 3'h1;
					if (q.bit_idx == 3'h7) begin
						d.st = MCM_RX_STOP;
					end
				end
			end
			MCM_RX_STOP: begin
				if (q.cnt != 12'h000) begin
					d.cnt = q.cnt - 12'h001;
				end else begin
					// Framing error drops the byte silently
					d.st = MCM_RX_IDLE;
					if (rx) begin
						d.data = q.shift;
						d.valid = 1'b1;
					end
				end
			end
			default: begin
				d.st = MCM_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{st: MCM_RX_IDLE, cnt: 12'h000, bit_idx: 3'h0,
				shift: 8'h00, data: 8'h00, valid: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign data  = q.data;
	assign valid = q.valid;

endmodule

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mcm_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module testbench;
	localparam int BC = 16;
	logic        mclk;
	logic        rst_b;
	logic        midi_in;
	logic [6:1]  enc_sw;
	logic        fb_det;
	logic        plug;
	logic        f_main;
	logic        f_sub;
	logic [1:0]  adr;
	logic        rd;
	logic        wr;
	logic [31:0] wd;
	logic [31:0] rdata;
	logic        wreq;
	logic        thru;
	logic [7:0]  preset;
	logic        pload;
	logic        mute;
	logic [1:0]  chan;
	logic        byp;
	logic [7:0]  ep;
	logic [31:0] q;
	logic [3:0]  c;
	logic [6:0]  p;
	logic [6:0]  vals [5] = '{7'h05, 7'h06, 7'h00, 7'h7f, 7'h04};
	int          check_count, n_mismatch, n_load, n_ld_exp, n_in_f, n_th_f;

	mcm_midi_ctrl #(.BIT_CYC(BC)) DUT (
		.mclk(mclk), .rst_b(rst_b), .midi_in(midi_in), .enc_sw(enc_sw),
		.footboard_det(fb_det), .fsw_plug(plug), .fsw_main(f_main),
		.secondary_channel_select(f_sub), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .midi_thru(thru),
		.preset(preset), .preset_load(pload), .master_mute(mute),
		.channel(chan), .bypass(byp)
	);

	mcm_midi_src #(.BIT_CYC(BC)) src (.mclk(mclk), .tx(midi_in));

	always #12.5 mclk = ~mclk;
	always @(posedge mclk) if (pload === 1'b1) n_load <= n_load + 1;
	always @(negedge midi_in) n_in_f++;
	always @(negedge thru) n_th_f++;

	function automatic logic [7:0] exp_pre(input logic [6:0] pn);
		return {1'b0, pn} + 8'h01;
	endfunction

	function automatic logic exp_mute(input logic [6:0] v);
		return v <= 7'h05;
	endfunction

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge mclk);
		while (wreq !== 1'b0 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50) n_mismatch++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic msg(input logic [7:0] s, a, b, input bit two);
		src.send(s);
		src.send(a);
		if (two) src.send(b);
		repeat (8) @(posedge mclk);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		mclk = 0; rst_b = 0; enc_sw = 6'h00; fb_det = 0; plug = 0; f_main = 0;
		f_sub = 0; adr = 0; rd = 0; wr = 0; wd = 0;
		void'($urandom(72549));
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (6) @(posedge mclk);
		`CHK(preset, 8'h01)
		`CHK({mute, chan, byp}, 4'h0)
		bus(1, `MCM_REG_CTRL, 32'h6);
		bus(0, `MCM_REG_CTRL, 0);
		`CHK(q[2:0], 3'h6)
		`CHK({chan, byp}, 3'h5)
		bus(0, 2'h3, 0);
		`CHK(q, 32'h0)
		plug <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			f_main <= k[1];
			f_sub <= k[0];
			repeat (8) @(posedge mclk);
			`CHK({chan, byp}, {k[1:0], 1'b0})
		end
		plug <= 1'b0;
		// Omni: other code switches hold a value that should not matter
		enc_sw <= 6'h1e;
		p = 7'($urandom);
		msg({4'hc, 4'($urandom)}, {1'b0, p}, 0, 0);
		ep = exp_pre(p);
		n_ld_exp = 1;
		`CHK(preset, ep)
		for (int k = 0; k < 6; k++) begin
			c = (k < 2) ? {4{k[0]}} : 4'($urandom);
			enc_sw[5:1] <= {c[0], c[1], c[2], c[3], 1'b1};
			p = 7'($urandom);
			msg({4'hc, c ^ 4'($urandom_range(15, 1))}, {1'b0, p}, 0, 0);
			`CHK(preset, ep)
			msg({4'hc, c}, {1'b0, p}, 0, 0);
			ep = exp_pre(p);
			n_ld_exp++;
			`CHK(preset, ep)
		end
		`CHK(n_load, n_ld_exp)
		bus(0, `MCM_REG_PRESET, 0);
		`CHK(q[7:0], ep)
		enc_sw[6] <= 1'b1;
		foreach (vals[i]) begin
			msg({4'hb, c}, 8'h07, {1'b0, vals[i]}, 1);
			`CHK(mute, exp_mute(vals[i]))
		end
		msg({4'hb, c}, 8'h08, 8'h7f, 1);
		msg({4'hd, c}, 8'h7f, 0, 0);
		`CHK(mute, 1'b1)
		enc_sw[6] <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK(mute, 1'b0)
		msg({4'hb, c}, 8'h07, 8'h00, 1);
		`CHK(mute, 1'b0)
		fb_det <= 1'b1;
		repeat (8) @(posedge mclk);
		msg({4'hc, c}, {1'b0, ~ep[6:0]}, 0, 0);
		`CHK(preset, ep)
		`CHK(n_load, n_ld_exp)
		fb_det <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK(n_th_f, n_in_f)
		`CHK(thru, 1'b1)
		bus(0, `MCM_REG_STATUS, 0);
		`CHK(q, {14'h0, 6'b110001, c, 4'h0, 1'b0, 1'b1, 2'h2})
		stop_test;
	end

	// Whole run is near 8.4k cycles at this bit length
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		stop_test;
	end
endmodule

`default_nettype wire
